// *** include/t16_cfg.svh ***
// offsets, field positions, reset values and fixed limits of the timer
`ifndef T16_CFG_SVH
`define T16_CFG_SVH

`define T16_OFS_CTRL_A   4'h0
`define T16_OFS_CTRL_B   4'h1
`define T16_OFS_FLAGS    4'h2
`define T16_OFS_CNT_LO   4'h4
`define T16_OFS_CNT_HI   4'h5
`define T16_OFS_CAP_LO   4'h6
`define T16_OFS_CAP_HI   4'h7
`define T16_OFS_CMPA_LO  4'h8
`define T16_OFS_CMPA_HI  4'h9
`define T16_OFS_CMPB_LO  4'hA
`define T16_OFS_CMPB_HI  4'hB
`define T16_OFS_CMPC_LO  4'hC
`define T16_OFS_CMPC_HI  4'hD

`define T16_CS_LSB       0
`define T16_CS_MSB       2
`define T16_WGMB_LSB     3
`define T16_WGMB_MSB     4
`define T16_WGMA_LSB     0
`define T16_WGMA_MSB     1
`define T16_OVF_BIT      0

`define T16_RST_BYTE     8'h00
`define T16_RST_WORD     16'h0000
`define T16_RST_CS       3'h0
`define T16_RST_WGM      4'h0

`define T16_ZERO         16'h0000
`define T16_MAX          16'hFFFF
`define T16_TOP_8BIT     16'h00FF
`define T16_TOP_9BIT     16'h01FF
`define T16_TOP_10BIT    16'h03FF

`define T16_CS_NONE      3'h0
`define T16_CS_EXT_FALL  3'h6
`define T16_CS_EXT_RISE  3'h7

`endif

// *** include/t16_pkg.sv ***
// types shared by the timer core and its register front end
package t16_pkg;

	typedef enum logic [1:0] {
		SEQ_NORMAL,
		SEQ_CTC,
		SEQ_FAST,
		SEQ_PHASE
	} t16_seq_type;

	typedef struct packed {
		t16_seq_type seq;
		logic [15:0] top;
	} t16_seq_cfg_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] value;
	} t16_load_type;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} t16_bus_type;

endpackage

// *** rtl/t16_counter_core.sv ***
// 16-bit up/down counter with top, zero and overflow detection
`timescale 1ns/10ps
`include "t16_cfg.svh"

module t16_counter_core (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     tick,
	input  wire t16_pkg::t16_seq_cfg_type cfg,
	input  wire t16_pkg::t16_load_type    load,
	output logic [15:0]                   count,
	output logic                          top_hit,
	output logic                          zero_hit,
	output logic                          ovf_pulse
);
	import t16_pkg::*;

	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic        down_r;
	logic        down_nxt;
	logic        top_r;
	logic        zero_r;
	logic        at_top;
	logic        at_zero;

	assign at_top  = (count_r == cfg.top);
	assign at_zero = (count_r == `T16_ZERO);

	always_comb begin
		count_nxt = count_r;
		down_nxt  = down_r;
		ovf_pulse = 1'b0;
		if (tick) begin
			// clear, up or down per mode
			case (cfg.seq)
				SEQ_NORMAL: begin
					down_nxt  = 1'b0;
					count_nxt = count_r + 16'h0001;
					ovf_pulse = (count_r == `T16_MAX);
				end
				SEQ_CTC: begin
					down_nxt  = 1'b0;
					count_nxt = at_top ? `T16_ZERO : count_r + 16'h0001;
					ovf_pulse = (count_r == `T16_MAX);
				end
				SEQ_FAST: begin
					down_nxt  = 1'b0;
					count_nxt = at_top ? `T16_ZERO : count_r + 16'h0001;
					ovf_pulse = at_top;
				end
				SEQ_PHASE: begin
					// turn at top and at zero; a zero top just holds
					if (at_top && at_zero) begin
						count_nxt = `T16_ZERO;
					end else if (!down_r && at_top) begin
						down_nxt  = 1'b1;
						count_nxt = count_r - 16'h0001;
					end else if (down_r && at_zero) begin
						down_nxt  = 1'b0;
						count_nxt = count_r + 16'h0001;
					end else if (down_r) begin
						count_nxt = count_r - 16'h0001;
					end else begin
						count_nxt = count_r + 16'h0001;
					end
					// overflow at zero_reached in dual slope
					ovf_pulse = at_zero && down_r;
				end
				default: begin
					count_nxt = count_r + 16'h0001;
				end
			endcase
		end
		// processor write beats clear and count
		if (load.valid) begin
			count_nxt = load.value;
			ovf_pulse = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_r <= `T16_RST_WORD;
			down_r  <= 1'b0;
		end else if (ce) begin
			count_r <= count_nxt;
			down_r  <= down_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			top_r  <= 1'b0;
			zero_r <= 1'b1;
		end else if (ce) begin
			top_r  <= (count_nxt == cfg.top);
			zero_r <= (count_nxt == `T16_ZERO);
		end
	end

	assign count    = count_r;
	assign top_hit  = top_r;
	assign zero_hit = zero_r;
endmodule

// *** rtl/t16_timer.sv ***
// 16-bit timer counter with byte-wide access through a shared high byte
//
// Function
// - 16-bit registers move as two byte accesses
// - one shared 8-bit temporary high byte
// - low write loads temp and byte together
// - counter and capture low reads copy high half into temp
// - compare high reads bypass the temporary byte
// - temp keeps its value after low writes
// - counter high location reaches the temp byte
// - clock select zero stops the counter
// - each tick clears, increments or decrements
// - counter accessible whether or not ticking
// - processor write beats clear and count
// - four-bit mode field sets the sequence
// - overflow flag set where mode says
// - up/down counter flags top and zero
// - clear forces every counter bit low
// - counter at two byte locations, high/low
// - zero is 0x0000, maximum 0xFFFF
// - top is fixed, compare A or capture
`timescale 1ns/10ps
`include "t16_cfg.svh"

module t16_timer #(
	parameter int ADDR_W = 4
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic              CE,
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic              WR_EN,
	input  wire logic              RD_EN,
	input  wire logic [7:0]        WDATA,
	input  wire logic [4:0]        PRE_TICKS,
	input  wire logic              EXT_CLK_PIN,
	output logic [7:0]             RDATA,
	output logic                   TOP_HIT,
	output logic                   ZERO_HIT,
	output logic                   OVF_FLAG
);
	import t16_pkg::*;

	// the register map needs four index bits
	generate
		if (ADDR_W < 4) begin : g_bad_addr_w
			$error("t16_timer: ADDR_W must be at least 4");
		end
	endgenerate

	t16_bus_type     bus;
	t16_seq_cfg_type seq_cfg;
	t16_load_type    load;

	logic [7:0]  temp_r;
	logic [7:0]  rdata_r;
	logic [7:0]  rdata_nxt;
	logic [2:0]  cs_r;
	logic [3:0]  wgm_r;
	logic        ovf_r;
	logic [15:0] cmpa_r;
	logic [15:0] cmpb_r;
	logic [15:0] cmpc_r;
	logic [15:0] cap_r;
	logic [15:0] count;
	logic        top_hit;
	logic        zero_hit;
	logic        ovf_pulse;
	logic        tick;
	logic        ext_meta_r;
	logic        ext_sync_r;
	logic        ext_prev_r;
	logic        hit;
	logic        wr_hit;
	logic        rd_hit;
	logic        cap_is_top;

	// upper address bits beyond the map make every access miss
	generate
		if (ADDR_W > 4) begin : g_wide
			assign hit = (ADDR[ADDR_W-1:4] == '0);
		end else begin : g_narrow
			assign hit = 1'b1;
		end
	endgenerate

	assign bus.wr    = WR_EN;
	assign bus.rd    = RD_EN;
	assign bus.addr  = ADDR[3:0];
	assign bus.wdata = WDATA;
	assign wr_hit    = bus.wr && hit;
	// a write wins a shared cycle, so temp never sees
	// two updates at one edge
	assign rd_hit    = bus.rd && hit && !bus.wr;

	// external clock pin: two-stage sync, then edge detect
	// edge flop resets low like an idle pin, so leaving
	// reset makes no false rising edge
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else if (CE) begin
			ext_meta_r <= EXT_CLK_PIN;
			ext_sync_r <= ext_meta_r;
			ext_prev_r <= ext_sync_r;
		end
	end

	// prescaler ticks come from this clock domain, so
	// they are used without a synchroniser
	// select tick source, zero stops
	always_comb begin
		case (cs_r)
			`T16_CS_NONE:     tick = 1'b0;
			`T16_CS_EXT_FALL: tick = ext_prev_r && !ext_sync_r;
			`T16_CS_EXT_RISE: tick = !ext_prev_r && ext_sync_r;
			default:          tick = PRE_TICKS[cs_r - 3'h1];
		endcase
	end

	// fixed, compare A or capture top
	always_comb begin
		seq_cfg.seq = SEQ_NORMAL;
		seq_cfg.top = `T16_MAX;
		cap_is_top  = 1'b0;
		case (wgm_r)
			4'h0: begin
				seq_cfg.seq = SEQ_NORMAL;
				seq_cfg.top = `T16_MAX;
			end
			4'h1: begin
				seq_cfg.seq = SEQ_PHASE;
				seq_cfg.top = `T16_TOP_8BIT;
			end
			4'h2: begin
				seq_cfg.seq = SEQ_PHASE;
				seq_cfg.top = `T16_TOP_9BIT;
			end
			4'h3: begin
				seq_cfg.seq = SEQ_PHASE;
				seq_cfg.top = `T16_TOP_10BIT;
			end
			4'h4: begin
				seq_cfg.seq = SEQ_CTC;
				seq_cfg.top = cmpa_r;
			end
			4'h5: begin
				seq_cfg.seq = SEQ_FAST;
				seq_cfg.top = `T16_TOP_8BIT;
			end
			4'h6: begin
				seq_cfg.seq = SEQ_FAST;
				seq_cfg.top = `T16_TOP_9BIT;
			end
			4'h7: begin
				seq_cfg.seq = SEQ_FAST;
				seq_cfg.top = `T16_TOP_10BIT;
			end
			4'h8, 4'hA: begin
				seq_cfg.seq = SEQ_PHASE;
				seq_cfg.top = cap_r;
				cap_is_top  = 1'b1;
			end
			4'h9, 4'hB: begin
				seq_cfg.seq = SEQ_PHASE;
				seq_cfg.top = cmpa_r;
			end
			4'hC: begin
				seq_cfg.seq = SEQ_CTC;
				seq_cfg.top = cap_r;
				cap_is_top  = 1'b1;
			end
			4'hE: begin
				seq_cfg.seq = SEQ_FAST;
				seq_cfg.top = cap_r;
				cap_is_top  = 1'b1;
			end
			4'hF: begin
				seq_cfg.seq = SEQ_FAST;
				seq_cfg.top = cmpa_r;
			end
			// reserved code runs as a free counter
			default: begin
				seq_cfg.seq = SEQ_NORMAL;
				seq_cfg.top = `T16_MAX;
			end
		endcase
	end

	// low write loads temp plus byte at once
	// load accepted with or without a tick
	assign load.valid = wr_hit && (bus.addr == `T16_OFS_CNT_LO);
	assign load.value = {temp_r, bus.wdata};

	t16_counter_core u_core (
		.clk       (CLK),
		.rst       (RST),
		.ce        (CE),
		.tick      (tick),
		.cfg       (seq_cfg),
		.load      (load),
		.count     (count),
		.top_hit   (top_hit),
		.zero_hit  (zero_hit),
		.ovf_pulse (ovf_pulse)
	);

	// interrupt code writing any pair or reading counter or capture between the two
	// bytes of a main-line access corrupts this byte
	// one temporary byte shared by all pairs
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			temp_r <= `T16_RST_BYTE;
		end else if (CE) begin
			if (wr_hit) begin
				case (bus.addr)
					`T16_OFS_CNT_HI,
					`T16_OFS_CAP_HI,
					`T16_OFS_CMPA_HI,
					`T16_OFS_CMPB_HI,
					`T16_OFS_CMPC_HI: temp_r <= bus.wdata;
					default: temp_r <= temp_r;
				endcase
			end else if (rd_hit) begin
				case (bus.addr)
					// low read snapshots the high half
					`T16_OFS_CNT_LO: temp_r <= count[15:8];
					`T16_OFS_CAP_LO: temp_r <= cap_r[15:8];
					default:         temp_r <= temp_r;
				endcase
			end
		end
	end

	// control bytes: mode field split over both
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cs_r  <= `T16_RST_CS;
			wgm_r <= `T16_RST_WGM;
		end else if (CE && wr_hit) begin
			if (bus.addr == `T16_OFS_CTRL_A) begin
				wgm_r[1:0] <= bus.wdata[`T16_WGMA_MSB:`T16_WGMA_LSB];
			end
			if (bus.addr == `T16_OFS_CTRL_B) begin
				wgm_r[3:2] <= bus.wdata[`T16_WGMB_MSB:`T16_WGMB_LSB];
				cs_r       <= bus.wdata[`T16_CS_MSB:`T16_CS_LSB];
			end
		end
	end

	// compare values load whole on their low write
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cmpa_r <= `T16_RST_WORD;
			cmpb_r <= `T16_RST_WORD;
			cmpc_r <= `T16_RST_WORD;
			cap_r  <= `T16_RST_WORD;
		end else if (CE && wr_hit) begin
			case (bus.addr)
				`T16_OFS_CMPA_LO: cmpa_r <= {temp_r, bus.wdata};
				`T16_OFS_CMPB_LO: cmpb_r <= {temp_r, bus.wdata};
				`T16_OFS_CMPC_LO: cmpc_r <= {temp_r, bus.wdata};
				// capture value is only writable when it is the top
				`T16_OFS_CAP_LO: begin
					if (cap_is_top) begin
						cap_r <= {temp_r, bus.wdata};
					end
				end
				default: begin
					cap_r <= cap_r;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ovf_r <= 1'b0;
		end else if (CE) begin
			// a set in the clearing cycle wins
			if (ovf_pulse) begin
				ovf_r <= 1'b1;
			end else if (wr_hit && bus.addr == `T16_OFS_FLAGS
					&& bus.wdata[`T16_OVF_BIT]) begin
				ovf_r <= 1'b0;
			end
		end
	end

	// compare halves read direct; counter and capture high read temp
	always_comb begin
		rdata_nxt = `T16_RST_BYTE;
		case (bus.addr)
			`T16_OFS_CTRL_A: begin
				rdata_nxt[`T16_WGMA_MSB:`T16_WGMA_LSB] = wgm_r[1:0];
			end
			`T16_OFS_CTRL_B: begin
				rdata_nxt[`T16_WGMB_MSB:`T16_WGMB_LSB] = wgm_r[3:2];
				rdata_nxt[`T16_CS_MSB:`T16_CS_LSB]     = cs_r;
			end
			`T16_OFS_FLAGS:   rdata_nxt[`T16_OVF_BIT] = ovf_r;
			`T16_OFS_CNT_LO:  rdata_nxt = count[7:0];
			`T16_OFS_CNT_HI:  rdata_nxt = temp_r;
			`T16_OFS_CAP_LO:  rdata_nxt = cap_r[7:0];
			`T16_OFS_CAP_HI:  rdata_nxt = temp_r;
			`T16_OFS_CMPA_LO: rdata_nxt = cmpa_r[7:0];
			`T16_OFS_CMPB_LO: rdata_nxt = cmpb_r[7:0];
			`T16_OFS_CMPC_LO: rdata_nxt = cmpc_r[7:0];
			`T16_OFS_CMPA_HI: rdata_nxt = cmpa_r[15:8];
			`T16_OFS_CMPB_HI: rdata_nxt = cmpb_r[15:8];
			`T16_OFS_CMPC_HI: rdata_nxt = cmpc_r[15:8];
			default:          rdata_nxt = `T16_RST_BYTE;
		endcase
	end

	// no ready line: data is valid the cycle after the strobe
	// read data is held until the next read
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rdata_r <= `T16_RST_BYTE;
		end else if (CE && rd_hit) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign RDATA    = rdata_r;
	assign TOP_HIT  = top_hit;
	assign ZERO_HIT = zero_hit;
	assign OVF_FLAG = ovf_r;
endmodule

// *** verification/t16_timer_properties.sv ***
// assertions on the timer's byte bus and status outputs
`timescale 1ns/10ps
module t16_timer_properties #(
	parameter int ADDR_W = 4
) (
	input wire logic              CLK,
	input wire logic              RST,
	input wire logic              CE,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic              WR_EN,
	input wire logic              RD_EN,
	input wire logic [7:0]        WDATA,
	input wire logic [4:0]        PRE_TICKS,
	input wire logic              EXT_CLK_PIN,
	input wire logic [7:0]        RDATA,
	input wire logic              TOP_HIT,
	input wire logic              ZERO_HIT,
	input wire logic              OVF_FLAG
);
	logic [2:0] cs_r;
	logic [3:0] mode_r;
	logic       quiet_r;
	wire logic  wr_ok = CE && WR_EN;
	wire logic  rd_ok = CE && RD_EN && !WR_EN;
	wire logic  at_lo = ADDR == ADDR_W'(4);
	wire logic  at_hi = ADDR == ADDR_W'(5);
	wire logic  w1c   = wr_ok && ADDR == ADDR_W'(2) && WDATA[0];
	// external selects are treated as ticking, to stay conservative
	wire logic  no_tick = cs_r == 3'h0
		|| (cs_r < 3'h6 && !PRE_TICKS[cs_r - 3'h1]);
	// a prescaler tick that surely advances the count
	wire logic  do_tick = cs_r != 3'h0 && cs_r < 3'h6
		&& PRE_TICKS[cs_r - 3'h1];

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cs_r <= 3'h0;
			mode_r <= 4'h0;
		end else if (wr_ok && ADDR == ADDR_W'(1)) begin
			cs_r <= WDATA[2:0];
			mode_r[3:2] <= WDATA[4:3];
		end else if (wr_ok && ADDR == ADDR_W'(0)) begin
			mode_r[1:0] <= WDATA[1:0];
		end
	end

	// flag may land one edge after its tick
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			quiet_r <= 1'b1;
		end else begin
			quiet_r <= no_tick;
		end
	end

	default clocking @(posedge CLK);
	endclocking
	default disable iff (RST);

	AST_RESET_VALUES: // reset values
	assert property ($fell(RST) |-> ZERO_HIT && !TOP_HIT && !OVF_FLAG
		&& RDATA == 8'h00) else $error("outputs not at reset values");
	AST_STOPPED: // no source stops
	assert property (CE && cs_r == 3'h0 && !WR_EN && !$past(WR_EN)
		|=> $stable(ZERO_HIT) && $stable(TOP_HIT))
		else $error("count moved while stopped");
	AST_COUNT_UP: // increment from zero
	assert property (CE && !WR_EN && mode_r == 4'h0 && do_tick && ZERO_HIT
		|=> !ZERO_HIT) else $error("tick at zero did not count");
	AST_OVF_QUIET: // set only by tick
	assert property (CE && no_tick && quiet_r && !OVF_FLAG |=> !OVF_FLAG)
		else $error("overflow flag set without a tick");
	AST_OVF_CLEAR: // one clears flag
	assert property (w1c && no_tick && quiet_r |=> !OVF_FLAG)
		else $error("overflow flag not cleared");
	AST_OVF_STICKY: // flag holds
	assert property (OVF_FLAG && !w1c |=> OVF_FLAG)
		else $error("overflow flag dropped by itself");
	AST_HI_TEMP: // high reads temp
	assert property (wr_ok && at_hi ##1 !WR_EN && !RD_EN ##1 rd_ok && at_hi
		|=> RDATA == $past(WDATA, 3)) else $error("high read not temp");
	AST_LO_NONZERO: // write beats count
	assert property (wr_ok && at_lo && WDATA != 8'h00 |=> !ZERO_HIT)
		else $error("nonzero write left zero flag");
	AST_ZERO_WRITE: // word load
	assert property (wr_ok && at_hi && WDATA == 8'h00 ##1 !WR_EN && !RD_EN
		##1 wr_ok && at_lo && WDATA == 8'h00 |=> ZERO_HIT)
		else $error("zero word not loaded");
	AST_TOP_MAX: // top at maximum
	assert property (mode_r == 4'h0 && wr_ok && at_hi && WDATA == 8'hFF
		##1 !WR_EN && !RD_EN ##1 wr_ok && at_lo && WDATA == 8'hFF
		|=> TOP_HIT) else $error("top not flagged at maximum");

	COV_TICK_WRITE: cover property (wr_ok && at_lo && !no_tick);
	COV_OVF: cover property ($rose(OVF_FLAG));
	COV_CMP_HI: cover property (rd_ok && ADDR == ADDR_W'(9));
endmodule

bind t16_timer t16_timer_properties #(.ADDR_W(ADDR_W)) u_props (
	.CLK(CLK), .RST(RST), .CE(CE), .ADDR(ADDR), .WR_EN(WR_EN),
	.RD_EN(RD_EN), .WDATA(WDATA), .PRE_TICKS(PRE_TICKS),
	.EXT_CLK_PIN(EXT_CLK_PIN), .RDATA(RDATA), .TOP_HIT(TOP_HIT),
	.ZERO_HIT(ZERO_HIT), .OVF_FLAG(OVF_FLAG));

// *** verification/t16_cpu_model.sv ***
// processor-side model issuing byte accesses to the timer
`timescale 1ns/10ps
module t16_cpu_model (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic [3:0]      addr,
	output logic            wr_en,
	output logic            rd_en,
	output logic [7:0]      wdata
);
	initial begin
		addr = 4'h3;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
		// released bus must not keep showing the byte
		wdata = ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd_en = 1'b1;
		@(posedge clk);
		#1;
		d = rdata;
		rd_en = 1'b0;
	endtask

	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		wr(lo + 4'h1, v[15:8]);
		wr(lo, v[7:0]);
	endtask

	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		rd(lo, v[7:0]);
		rd(lo + 4'h1, v[15:8]);
	endtask
endmodule

// *** verification/t16_timer_tb_top.sv ***
// self-checking bench for the byte-access timer
`timescale 1ns/10ps
`include "t16_cfg.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	err_total++; $display("unexpected at %0t: got %h want %h", \
	$time, got, exp); end end
module t16_timer_tb_top;
	localparam logic [3:0] CNT = `T16_OFS_CNT_LO;
	logic        clk;
	logic        rst;
	logic        ce;
	logic        wr_en;
	logic        rd_en;
	logic        ext_pin;
	logic        top_hit;
	logic        zero_hit;
	logic        ovf_flag;
	logic [3:0]  addr;
	logic [4:0]  pre_ticks;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [7:0]  b;
	logic [15:0] w;
	logic [47:0] m;
	int          err_total;
	int          comparisons;
	// ctrl A, ctrl B, top, count after one tick at top
	logic [47:0] mode_tab [15] = '{
		48'h0109_00FF_0000, 48'h0209_01FF_0000, 48'h0309_03FF_0000,
		48'h0101_00FF_00FE, 48'h0201_01FF_01FE, 48'h0301_03FF_03FE,
		48'h0009_5A01_0000, 48'h0111_5A01_5A00, 48'h0311_5A01_5A00,
		48'h0319_5A01_0000, 48'h0119_FFFF_0000, 48'h0011_0123_0122,
		48'h0211_0123_0122, 48'h0019_0123_0000, 48'h0219_0123_0000};

	t16_timer #(.ADDR_W(4)) uut (.CLK(clk), .RST(rst), .CE(ce),
		.ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en), .WDATA(wdata),
		.PRE_TICKS(pre_ticks), .EXT_CLK_PIN(ext_pin), .RDATA(rdata),
		.TOP_HIT(top_hit), .ZERO_HIT(zero_hit), .OVF_FLAG(ovf_flag));
	t16_cpu_model cpu (.clk(clk), .rdata(rdata), .addr(addr),
		.wr_en(wr_en), .rd_en(rd_en), .wdata(wdata));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic tick(input logic [4:0] mask);
		@(posedge clk);
		#1;
		pre_ticks = mask;
		@(posedge clk);
		#1;
		pre_ticks = 5'h00;
	endtask

	initial begin
		#100000;
		err_total++;
		$display("unexpected at %0t: run did not finish", $time);
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		pre_ticks = 5'h00;
		ext_pin = 1'b0;
		err_total = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		#1;
		rst = 1'b0;
		cpu.rd16(CNT, w);
		`CHK(w, 16'h0000)
		`CHK({zero_hit, top_hit, ovf_flag}, 3'h4)
		cpu.rd(4'h1, b);
		`CHK(b, 8'h00)
		cpu.rd(4'h3, b);
		`CHK(b, 8'h00)
		$display("test reset done");
		cpu.wr16(CNT, 16'h01FF);
		cpu.rd16(CNT, w);
		`CHK(w, 16'h01FF)
		`CHK({zero_hit, top_hit}, 2'h0)
		$display("test word access done");
		cpu.wr(4'h5, 8'h5A);
		cpu.wr(4'h8, 8'h01);
		cpu.wr(4'h4, 8'h02);
		cpu.wr(4'h5, 8'h77);
		cpu.rd(4'h5, b);
		`CHK(b, 8'h77)
		cpu.rd(4'h9, b);
		`CHK(b, 8'h5A)
		cpu.rd16(4'h8, w);
		`CHK(w, 16'h5A01)
		cpu.rd16(CNT, w);
		`CHK(w, 16'h5A02)
		$display("test shared temp done");
		repeat (3) tick(5'h1F);
		cpu.rd16(CNT, w);
		`CHK(w, 16'h5A02)
		cpu.wr(4'h1, 8'h01);
		tick(5'h1E);
		repeat (3) tick(5'h01);
		// a low clock enable freezes the counter
		ce = 1'b0;
		tick(5'h01);
		ce = 1'b1;
		cpu.rd16(CNT, w);
		`CHK(w, 16'h5A05)
		cpu.wr(4'h5, 8'h12);
		fork
			cpu.wr(4'h4, 8'h34);
			tick(5'h01);
		join
		cpu.rd16(CNT, w);
		`CHK(w, 16'h1234)
		$display("test counting done");
		cpu.wr16(CNT, 16'hFFFF);
		`CHK(top_hit, 1'b1)
		tick(5'h01);
		for (int i = 0; i < 3 && ovf_flag !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK(ovf_flag, 1'b1)
		`CHK(zero_hit, 1'b1)
		tick(5'h01);
		cpu.rd16(CNT, w);
		`CHK(w, 16'h0001)
		cpu.wr(4'h2, 8'h01);
		`CHK(ovf_flag, 1'b0)
		$display("test overflow done");
		// capture is writable only while it sets the top
		cpu.wr16(4'h6, 16'h0123);
		cpu.rd16(4'h6, w);
		`CHK(w, 16'h0000)
		for (int i = 0; i < 15; i++) begin
			m = mode_tab[i];
			cpu.wr(4'h0, m[47:40]);
			cpu.wr(4'h1, m[39:32]);
			cpu.wr16(4'h6, 16'h0123);
			cpu.wr16(CNT, m[31:16]);
			`CHK(top_hit, 1'b1)
			tick(5'h01);
			cpu.rd16(CNT, w);
			`CHK(w, m[15:0])
		end
		cpu.rd16(4'h6, w);
		`CHK(w, 16'h0123)
		$display("test modes done");
		cpu.wr(4'h0, 8'h00);
		cpu.wr(4'h1, 8'h07);
		cpu.wr16(CNT, 16'h0000);
		ext_pin = 1'b1;
		repeat (5) @(posedge clk);
		cpu.rd16(CNT, w);
		`CHK(w, 16'h0001)
		ext_pin = 1'b0;
		repeat (5) @(posedge clk);
		cpu.rd16(CNT, w);
		`CHK(w, 16'h0001)
		cpu.wr(4'h1, 8'h06);
		ext_pin = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		ext_pin = 1'b0;
		repeat (5) @(posedge clk);
		cpu.rd16(CNT, w);
		`CHK(w, 16'h0002)
		$display("test external source done");
		cpu.wr(4'h5, 8'h33);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		`CHK({zero_hit, top_hit, ovf_flag, rdata}, 11'h400)
		cpu.rd(4'h5, b);
		`CHK(b, 8'h00)
		cpu.rd16(CNT, w);
		`CHK(w, 16'h0000)
		cpu.rd(4'h0, b);
		`CHK(b, 8'h00)
		cpu.rd(4'h1, b);
		`CHK(b, 8'h00)
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
